// *** dcr_pkg.sv ***
// Shared constants and carriers for the disk control error recovery block.
// Assumes one 25 MHz core clock and a synchronous active-low reset.
package dcr_pkg;
  localparam int DRV_W = 3;
  localparam int TRK_W = 16;
  localparam int XFER_W = 16;
  localparam int PAT_W = 24;
  localparam int DISP_W = 16;
  localparam int BYTE_CNT_W = 32;
  localparam int SEEK_CNT_W = 16;
  localparam int ERR_CNT_W = 8;
  localparam int TRY_W = 4;
  localparam int CHK_W = 4;

  localparam logic [TRY_W-1:0] UNCORR_RETRIES = 4'h2;
  localparam logic [TRY_W-1:0] SEEK_RETRIES = 4'ha;
  localparam logic [TRY_W-1:0] OVERRUN_RETRIES = 4'h1;
  localparam logic [TRY_W-1:0] HAK_PLAIN_RETRIES = 4'h1;
  localparam logic [CHK_W-1:0] CHK_BYTES_ECC = 4'ha;
  localparam logic [CHK_W-1:0] CHK_BYTES_CRC = 4'h2;

  localparam logic [BYTE_CNT_W-1:0] BYTE_THR_DEF = 32'hffff_0000;
  localparam logic [SEEK_CNT_W-1:0] SEEK_THR_DEF = 16'hff00;
  localparam logic [ERR_CNT_W-1:0] ERR_THR_DEF = 8'h10;

  // Outcome of one command execution, reported by the sequencer
  typedef struct packed {
    logic corr_data;
    logic corr_hak;
    logic uncorr;
    logic seek_fail;
    logic alt_track;
    logic overrun;
  } dcr_err_t;

  typedef enum logic [2:0] {
    KIND_NONE, KIND_CORR, KIND_UNCORR, KIND_SEEK, KIND_OTHER
  } dcr_kind_t;

  typedef struct packed {
    logic [BYTE_CNT_W-1:0] bytes_rd;
    logic [SEEK_CNT_W-1:0] seeks;
    logic [ERR_CNT_W-1:0] seek_err;
    logic [ERR_CNT_W-1:0] corr_err;
    logic [ERR_CNT_W-1:0] uncorr_err;
  } dcr_cnt_t;

  typedef struct packed {
    logic valid;
    logic [PAT_W-1:0] pattern;
    logic [DISP_W-1:0] disp;
  } dcr_sense_t;

  localparam dcr_cnt_t CNT_RST = '0;
  localparam dcr_sense_t SENSE_RST = '0;
endpackage

// *** dcr_drive_counters.sv ***
// Usage and error counters of one drive, saturating, with threshold flag.
// Assumes increments and clear come from logic on the same clock.
module dcr_drive_counters import dcr_pkg::*; #(
  parameter logic [BYTE_CNT_W-1:0] BYTE_THR = BYTE_THR_DEF,
  parameter logic [SEEK_CNT_W-1:0] SEEK_THR = SEEK_THR_DEF,
  parameter logic [ERR_CNT_W-1:0] ERR_THR = ERR_THR_DEF
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic add_en,
  input wire logic [XFER_W-1:0] add_bytes,
  input wire logic seek_inc,
  input wire dcr_kind_t kind_inc,
  input wire logic clr,
  output dcr_cnt_t cnt_r,
  output logic thr_r
);
  dcr_cnt_t cnt_nxt;
  dcr_cnt_t base;
  logic thr_nxt;
  logic [BYTE_CNT_W:0] bsum;

  function automatic logic [ERR_CNT_W-1:0] sat_inc(
    input logic [ERR_CNT_W-1:0] v, input logic en);
    sat_inc = (en && v != '1) ? v + 1'b1 : v;
  endfunction

  always_comb begin
    // Clear first so an event in the clear cycle still counts
    base = clr ? CNT_RST : cnt_r;
    cnt_nxt = base;
    bsum = {1'b0, base.bytes_rd} + {{(BYTE_CNT_W+1-XFER_W){1'b0}}, add_bytes};
    if (add_en) begin
      cnt_nxt.bytes_rd = bsum[BYTE_CNT_W] ? '1 : bsum[BYTE_CNT_W-1:0];
    end
    if (seek_inc && base.seeks != '1) begin
      cnt_nxt.seeks = base.seeks + 1'b1;
    end
    cnt_nxt.seek_err = sat_inc(base.seek_err, kind_inc == KIND_SEEK);
    cnt_nxt.corr_err = sat_inc(base.corr_err, kind_inc == KIND_CORR);
    cnt_nxt.uncorr_err = sat_inc(base.uncorr_err, kind_inc == KIND_UNCORR);
    thr_nxt = cnt_nxt.bytes_rd >= BYTE_THR || cnt_nxt.seeks >= SEEK_THR ||
              cnt_nxt.seek_err >= ERR_THR || cnt_nxt.corr_err >= ERR_THR ||
              cnt_nxt.uncorr_err >= ERR_THR;
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      cnt_r <= CNT_RST;
      thr_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      thr_r <= thr_nxt;
    end
  end
endmodule

// *** dcr_recovery.sv ***
// Error recovery, retry sequencing, per-drive logging and track sparing.
// Assumes a command sequencer on core_clk reports starts and outcomes;
// drive pack and diagnostic plug pins arrive asynchronously.
module dcr_recovery import dcr_pkg::*; #(
  parameter int NUM_DRV = 8,
  parameter bit VARIANT2 = 1'b0,
  parameter logic [BYTE_CNT_W-1:0] BYTE_THR = BYTE_THR_DEF,
  parameter logic [SEEK_CNT_W-1:0] SEEK_THR = SEEK_THR_DEF,
  parameter logic [ERR_CNT_W-1:0] ERR_THR = ERR_THR_DEF
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic cmd_start,
  input wire logic [DRV_W-1:0] cmd_drive,
  input wire logic [TRK_W-1:0] cmd_track,
  input wire logic op_end,
  input wire dcr_err_t op_err,
  input wire logic [PAT_W-1:0] ecc_pattern,
  input wire logic [DISP_W-1:0] ecc_disp,
  input wire logic [XFER_W-1:0] xfer_bytes,
  input wire logic seek_issued,
  input wire logic orient_done,
  input wire logic [TRK_W-1:0] alt_loc,
  input wire logic alt_seek_done,
  input wire logic index_found,
  input wire logic rps_set,
  input wire logic [DRV_W-1:0] rps_drive,
  input wire logic rps_done,
  input wire logic [DRV_W-1:0] rps_done_drive,
  input wire logic spare_assign,
  input wire logic [DRV_W-1:0] spare_drive,
  input wire logic [TRK_W-1:0] spare_bad_trk,
  input wire logic [TRK_W-1:0] spare_alt_trk,
  input wire logic log_rd,
  input wire logic [DRV_W-1:0] log_drive,
  input wire logic [NUM_DRV-1:0] pack_removed_pin,
  input wire logic [NUM_DRV-1:0] diag_plug_pin,
  output logic retry_req_r,
  output logic disconnect_r,
  output logic buf_fix_r,
  output logic use_buf_r,
  output logic seek_req_r,
  output logic [TRK_W-1:0] seek_trk_r,
  output logic orient_req_r,
  output logic [TRK_W-1:0] eff_trk_r,
  output dcr_sense_t sense_r,
  output logic unit_check_r,
  output logic cmd_reject_r,
  output logic err_final_r,
  output logic done_r,
  output logic rps_reject_r,
  output logic [NUM_DRV-1:0] rps_active_r,
  output logic [NUM_DRV-1:0] offline_r,
  output dcr_cnt_t log_data_r,
  output logic log_valid_r,
  output logic [CHK_W-1:0] chk_bytes_r
);
  if (NUM_DRV < 1 || NUM_DRV > (1 << DRV_W)) begin : g_chk
    $error("NUM_DRV out of range for drive id width");
  end

  typedef enum logic [2:0] {
    ST_IDLE, ST_RUN, ST_REORIENT, ST_ALT_SEEK, ST_ALT_INDEX
  } dcr_state_t;

  // Pin synchronisers; only the second stage and later are read
  logic [NUM_DRV-1:0] pack_q1_r, pack_q2_r, pack_q3_r;
  logic [NUM_DRV-1:0] diag_q1_r;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      pack_q1_r <= '0;
      pack_q2_r <= '0;
      pack_q3_r <= '0;
      diag_q1_r <= '0;
      offline_r <= '0;
    end else begin
      pack_q1_r <= pack_removed_pin;
      pack_q2_r <= pack_q1_r;
      pack_q3_r <= pack_q2_r;
      diag_q1_r <= diag_plug_pin;
      offline_r <= diag_q1_r;
    end
  end

  // Per-drive counters and bookkeeping
  dcr_cnt_t cnt_a [NUM_DRV];
  logic [NUM_DRV-1:0] thr_w;
  logic [NUM_DRV-1:0] thr_q_r;
  logic [NUM_DRV-1:0] uc_pend_r, uc_pend_nxt;
  logic [NUM_DRV-1:0] rps_nxt;
  logic [NUM_DRV-1:0] sp_vld_r, sp_vld_nxt;
  logic [TRK_W-1:0] sp_bad_r [NUM_DRV];
  logic [TRK_W-1:0] sp_alt_r [NUM_DRV];
  dcr_kind_t kind_inc;
  logic add_en;
  logic [DRV_W-1:0] cur_drv_r, cur_drv_nxt;

  for (genvar d = 0; d < NUM_DRV; d++) begin : g_drv
    dcr_drive_counters #(
      .BYTE_THR(BYTE_THR),
      .SEEK_THR(SEEK_THR),
      .ERR_THR(ERR_THR)
    ) u_cnt (
      .core_clk(core_clk),
      .rstn(rstn),
      .add_en(add_en && cur_drv_r == DRV_W'(d)),
      .add_bytes(xfer_bytes),
      .seek_inc(seek_issued && cur_drv_r == DRV_W'(d)),
      .kind_inc(cur_drv_r == DRV_W'(d) ? kind_inc : KIND_NONE),
      .clr(log_rd && log_drive == DRV_W'(d)),
      .cnt_r(cnt_a[d]),
      .thr_r(thr_w[d])
    );
  end

  // Recovery sequencer state
  dcr_state_t st_r, st_nxt;
  dcr_kind_t pend_kind_r, pend_kind_nxt;
  logic [TRY_W-1:0] tries_r, tries_nxt;
  logic use_buf_nxt, buf_fix_nxt, retry_nxt, seek_req_nxt, orient_nxt;
  logic unit_check_nxt, reject_nxt, final_nxt, done_nxt, rps_rej_nxt;
  logic [TRK_W-1:0] seek_trk_nxt, eff_trk_nxt;
  dcr_sense_t sense_nxt;
  logic hak_buffer;

  // Decide whether another attempt remains, else end with an error
  function automatic logic can_retry(input logic [TRY_W-1:0] t,
                                     input logic [TRY_W-1:0] lim);
    can_retry = t < lim;
  endfunction

  always_comb begin
    st_nxt = st_r;
    pend_kind_nxt = pend_kind_r;
    tries_nxt = tries_r;
    cur_drv_nxt = cur_drv_r;
    use_buf_nxt = use_buf_r;
    eff_trk_nxt = eff_trk_r;
    seek_trk_nxt = seek_trk_r;
    sense_nxt = sense_r;
    buf_fix_nxt = 1'b0;
    retry_nxt = 1'b0;
    seek_req_nxt = 1'b0;
    orient_nxt = 1'b0;
    unit_check_nxt = 1'b0;
    reject_nxt = 1'b0;
    final_nxt = 1'b0;
    done_nxt = 1'b0;
    kind_inc = KIND_NONE;
    add_en = 1'b0;
    hak_buffer = 1'b0;
    // Threshold crossing or pack removal arms unit check; set beats clear
    uc_pend_nxt = uc_pend_r;
    if (cmd_start && st_r == ST_IDLE && !offline_r[cmd_drive]) begin
      uc_pend_nxt[cmd_drive] = 1'b0;
    end
    uc_pend_nxt = uc_pend_nxt | (thr_w & ~thr_q_r) |
                  (pack_q2_r & ~pack_q3_r);
    case (st_r)
      ST_IDLE: begin
        if (cmd_start) begin
          if (offline_r[cmd_drive]) begin
            reject_nxt = 1'b1;
          end else if (uc_pend_r[cmd_drive]) begin
            unit_check_nxt = 1'b1;
          end else begin
            cur_drv_nxt = cmd_drive;
            tries_nxt = '0;
            pend_kind_nxt = KIND_NONE;
            use_buf_nxt = 1'b0;
            sense_nxt = SENSE_RST;
            eff_trk_nxt = (sp_vld_r[cmd_drive] &&
                           sp_bad_r[cmd_drive] == cmd_track) ?
                          sp_alt_r[cmd_drive] : cmd_track;
            st_nxt = ST_RUN;
          end
        end
      end
      ST_RUN: begin
        if (op_end) begin
          add_en = 1'b1;
          tries_nxt = tries_r + 1'b1;
          st_nxt = ST_REORIENT;
          if (op_err.seek_fail) begin
            pend_kind_nxt = KIND_SEEK;
            if (!can_retry(tries_r, SEEK_RETRIES)) begin
              st_nxt = ST_IDLE;
              final_nxt = 1'b1;
            end
          end else if (op_err.alt_track) begin
            seek_req_nxt = 1'b1;
            seek_trk_nxt = alt_loc;
            eff_trk_nxt = alt_loc;
            pend_kind_nxt = KIND_OTHER;
            st_nxt = ST_ALT_SEEK;
          end else if (op_err.overrun) begin
            pend_kind_nxt = KIND_OTHER;
            if (!can_retry(tries_r, OVERRUN_RETRIES)) begin
              st_nxt = ST_IDLE;
              final_nxt = 1'b1;
            end
          end else if (op_err.uncorr) begin
            pend_kind_nxt = KIND_UNCORR;
            if (!can_retry(tries_r, UNCORR_RETRIES)) begin
              st_nxt = ST_IDLE;
              final_nxt = 1'b1;
            end
          end else if (op_err.corr_hak) begin
            pend_kind_nxt = KIND_CORR;
            // Second variant tries the track once before the buffer
            hak_buffer = !VARIANT2 ||
                         !can_retry(tries_r, HAK_PLAIN_RETRIES);
            if (use_buf_r) begin
              st_nxt = ST_IDLE;
              final_nxt = 1'b1;
            end else if (hak_buffer) begin
              buf_fix_nxt = 1'b1;
              use_buf_nxt = 1'b1;
            end
          end else begin
            // Data-area correction is left to the host routine
            if (op_err.corr_data) begin
              sense_nxt = '{valid: 1'b1, pattern: ecc_pattern,
                            disp: ecc_disp};
            end
            if (pend_kind_r != KIND_OTHER) begin
              kind_inc = pend_kind_r;
            end
            done_nxt = 1'b1;
            st_nxt = ST_IDLE;
          end
        end
      end
      ST_ALT_SEEK: begin
        if (alt_seek_done) begin
          orient_nxt = 1'b1;
          st_nxt = ST_ALT_INDEX;
        end
      end
      ST_ALT_INDEX: begin
        if (index_found) begin
          retry_nxt = 1'b1;
          st_nxt = ST_RUN;
        end
      end
      ST_REORIENT: begin
        if (orient_done) begin
          retry_nxt = 1'b1;
          st_nxt = ST_RUN;
        end
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      st_r <= ST_IDLE;
      pend_kind_r <= KIND_NONE;
      tries_r <= '0;
      cur_drv_r <= '0;
      use_buf_r <= 1'b0;
      buf_fix_r <= 1'b0;
      retry_req_r <= 1'b0;
      seek_req_r <= 1'b0;
      seek_trk_r <= '0;
      orient_req_r <= 1'b0;
      eff_trk_r <= '0;
      sense_r <= SENSE_RST;
      unit_check_r <= 1'b0;
      cmd_reject_r <= 1'b0;
      err_final_r <= 1'b0;
      done_r <= 1'b0;
      disconnect_r <= 1'b0;
      uc_pend_r <= '0;
      thr_q_r <= '0;
    end else begin
      st_r <= st_nxt;
      pend_kind_r <= pend_kind_nxt;
      tries_r <= tries_nxt;
      cur_drv_r <= cur_drv_nxt;
      use_buf_r <= use_buf_nxt;
      buf_fix_r <= buf_fix_nxt;
      retry_req_r <= retry_nxt;
      seek_req_r <= seek_req_nxt;
      seek_trk_r <= seek_trk_nxt;
      orient_req_r <= orient_nxt;
      eff_trk_r <= eff_trk_nxt;
      sense_r <= sense_nxt;
      unit_check_r <= unit_check_nxt;
      cmd_reject_r <= reject_nxt;
      err_final_r <= final_nxt;
      done_r <= done_nxt;
      // Channel is free for other drives while reorienting or seeking and orienting on an alternate track
      disconnect_r <= st_nxt inside {ST_REORIENT, ST_ALT_SEEK,
                                     ST_ALT_INDEX};
      uc_pend_r <= uc_pend_nxt;
      thr_q_r <= thr_w;
    end
  end

  // Sensing programs, spare table and log readout
  always_comb begin
    rps_nxt = rps_active_r;
    rps_rej_nxt = 1'b0;
    sp_vld_nxt = sp_vld_r;
    if (rps_done) begin
      rps_nxt[rps_done_drive] = 1'b0;
    end
    if (rps_set) begin
      if (rps_active_r[rps_drive] || offline_r[rps_drive]) begin
        rps_rej_nxt = 1'b1;
      end else begin
        rps_nxt[rps_drive] = 1'b1;
      end
    end
    if (spare_assign) begin
      sp_vld_nxt[spare_drive] = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      rps_active_r <= '0;
      rps_reject_r <= 1'b0;
      sp_vld_r <= '0;
      log_data_r <= CNT_RST;
      log_valid_r <= 1'b0;
      chk_bytes_r <= CHK_BYTES_CRC;
    end else begin
      rps_active_r <= rps_nxt;
      rps_reject_r <= rps_rej_nxt;
      sp_vld_r <= sp_vld_nxt;
      log_valid_r <= log_rd;
      if (log_rd) begin
        log_data_r <= cnt_a[log_drive];
      end
      chk_bytes_r <= VARIANT2 ? CHK_BYTES_ECC : CHK_BYTES_CRC;
    end
  end

  // Spare table storage needs no reset; valid bits guard it
  always_ff @(posedge core_clk) begin
    if (spare_assign) begin
      sp_bad_r[spare_drive] <= spare_bad_trk;
      sp_alt_r[spare_drive] <= spare_alt_trk;
    end
  end
endmodule

// *** dcr_chan_model.sv ***
// Channel-side model for the recovery block: answers reorient, alternate
// seek and index waits after a set latency, and counts reissued commands.
// Assumes the block's outputs change on the rising edge of core_clk.
module dcr_chan_model import dcr_pkg::*; (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [3:0] lat,
  input wire logic disconnect_r,
  input wire logic seek_req_r,
  input wire logic orient_req_r,
  input wire logic retry_req_r,
  output logic orient_done,
  output logic alt_seek_done,
  output logic index_found,
  output int n_reissue
);
  logic [1:0] wt;
  logic [3:0] cnt;
  logic dprev;
  logic fire;
  assign fire = wt != 2'd0 && cnt == 4'h0;
  // A slow answer keeps the block parked in its disconnected wait
  always @(negedge core_clk) begin
    dprev <= disconnect_r;
    if (!rstn) begin
      wt <= 2'd0;
      cnt <= 4'h0;
      n_reissue <= 0;
      {orient_done, alt_seek_done, index_found} <= 3'h0;
    end else begin
      if (retry_req_r === 1'b1)
        n_reissue <= n_reissue + 1;
      orient_done <= fire && wt == 2'd1;
      alt_seek_done <= fire && wt == 2'd2;
      index_found <= fire && wt == 2'd3;
      if (wt != 2'd0 && cnt != 4'h0)
        cnt <= cnt - 4'h1;
      else if (wt != 2'd0)
        wt <= 2'd0;
      else if (seek_req_r || orient_req_r || disconnect_r && !dprev) begin
        wt <= seek_req_r ? 2'd2 : orient_req_r ? 2'd3 : 2'd1;
        cnt <= lat;
      end
    end
  end
endmodule

// *** dcr_recovery_assertions.sv ***
// Port-level checks of the recovery block, bound into every instance.
// Assumes one clock domain and the designer's one-cycle answer latency.
module dcr_recovery_chk import dcr_pkg::*; #(
  parameter int NUM_DRV = 8,
  parameter bit VARIANT2 = 1'b0
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic cmd_start,
  input wire logic [DRV_W-1:0] cmd_drive,
  input wire logic op_end,
  input wire dcr_err_t op_err,
  input wire logic [PAT_W-1:0] ecc_pattern,
  input wire logic [DISP_W-1:0] ecc_disp,
  input wire logic orient_done,
  input wire logic alt_seek_done,
  input wire logic orient_req_r,
  input wire logic [TRK_W-1:0] alt_loc,
  input wire logic index_found,
  input wire logic rps_set,
  input wire logic [DRV_W-1:0] rps_drive,
  input wire logic rps_done,
  input wire logic log_rd,
  input wire logic retry_req_r,
  input wire logic disconnect_r,
  input wire logic seek_req_r,
  input wire logic [TRK_W-1:0] seek_trk_r,
  input wire dcr_sense_t sense_r,
  input wire logic unit_check_r,
  input wire logic cmd_reject_r,
  input wire logic err_final_r,
  input wire logic done_r,
  input wire logic rps_reject_r,
  input wire logic [NUM_DRV-1:0] rps_active_r,
  input wire logic [NUM_DRV-1:0] offline_r,
  input wire logic log_valid_r,
  input wire logic [CHK_W-1:0] chk_bytes_r
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  chk_corr_sense: assert property (op_end && op_err == 6'h20
    |=> done_r && sense_r == {1'b1, $past(ecc_pattern), $past(ecc_disp)})
    else $error("corrected data sense wrong");
  chk_orient_retry: assert property (disconnect_r && orient_done
    |=> retry_req_r && !disconnect_r)
    else $error("no reissue after reorient");
  chk_alt_seek: assert property (op_end && op_err == 6'h02
    |=> seek_req_r && disconnect_r && seek_trk_r == $past(alt_loc))
    else $error("alternate seek wrong");
  chk_alt_orient: assert property (disconnect_r && alt_seek_done
    |=> orient_req_r && disconnect_r)
    else $error("no index wait after alternate seek");
  chk_index_retry: assert property (disconnect_r && index_found
    |=> retry_req_r)
    else $error("no reissue after index");
  chk_one_outcome: assert property ($onehot0({done_r, err_final_r,
    retry_req_r, cmd_reject_r, unit_check_r}))
    else $error("two outcomes at once");
  chk_reject_cause: assert property (cmd_reject_r
    |-> $past(cmd_start) && $past(offline_r[cmd_drive]))
    else $error("reject without offline drive");
  chk_uc_cause: assert property (unit_check_r |-> $past(cmd_start))
    else $error("unit check without start");
  chk_log_answer: assert property (log_rd |=> log_valid_r)
    else $error("log read unanswered");
  chk_rps_busy: assert property (rps_set && !rps_done
    && (rps_active_r[rps_drive] || offline_r[rps_drive]) |=> rps_reject_r)
    else $error("busy sensing slot not refused");
  chk_check_bytes: assert property ($past(rstn)
    |-> chk_bytes_r == (VARIANT2 ? 4'ha : 4'h2))
    else $error("check byte count wrong");
  cov_retry_ok: cover property (retry_req_r ##[1:60] done_r);
  cov_final: cover property (err_final_r);
  cov_unit_check: cover property (unit_check_r);
endmodule
bind dcr_recovery dcr_recovery_chk #(.NUM_DRV(NUM_DRV),
  .VARIANT2(VARIANT2)) chk_u (.*);

// *** test_dcr_recovery.sv ***
// Self-checking bench for the disk control error recovery block.
// Assumes the channel model answers all disconnected waits.
module test_dcr_recovery import dcr_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rstn, cmd_start, op_end, seek_issued, rps_set, rps_done;
  logic spare_assign, log_rd, orient_done, alt_seek_done, index_found;
  logic [DRV_W-1:0] cmd_drive, rps_drive, rps_done_drive, spare_drive;
  logic [DRV_W-1:0] log_drive;
  logic [TRK_W-1:0] cmd_track, alt_loc, spare_bad_trk, spare_alt_trk;
  logic [TRK_W-1:0] seek_trk_r, eff_trk_r;
  logic [PAT_W-1:0] ecc_pattern;
  logic [DISP_W-1:0] ecc_disp;
  logic [XFER_W-1:0] xfer_bytes;
  logic [7:0] pack_removed_pin, diag_plug_pin, rps_active_r, offline_r;
  logic retry_req_r, disconnect_r, buf_fix_r, use_buf_r, seek_req_r;
  logic orient_req_r, unit_check_r, cmd_reject_r, err_final_r, done_r;
  logic rps_reject_r, log_valid_r, saw_fix, saw_disc;
  logic [CHK_W-1:0] chk_bytes_r;
  logic [3:0] lat;
  logic [1:0] res;
  dcr_err_t op_err;
  dcr_sense_t sense_r;
  dcr_cnt_t log_data_r;
  int n_mismatch, n_compared, n_reissue;
  int cyc = 0;
  // Low error threshold so the unit check path is reached quickly
  dcr_recovery #(.ERR_THR(8'h02)) dut_u (.*);
  dcr_chan_model chan_u (.*);
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  task automatic report_and_stop();
    if (n_mismatch == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  task automatic chk(input logic ok, input string m);
    n_compared++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task automatic start(input int d, input logic [TRK_W-1:0] t);
    @(negedge core_clk);
    cmd_start = 1'b1;
    cmd_drive = d[DRV_W-1:0];
    cmd_track = t;
    @(negedge core_clk);
    cmd_start = 1'b0;
  endtask
  // res: 1 reissue asked, 2 done, 3 retries exhausted, 0 nothing
  task automatic attempt(input dcr_err_t e);
    @(negedge core_clk);
    op_end = 1'b1;
    op_err = e;
    @(negedge core_clk);
    op_end = 1'b0;
    op_err = '0;
    res = 2'd0;
    saw_fix = 1'b0;
    saw_disc = 1'b0;
    for (int i = 0; i < 200 && res == 2'd0; i++) begin
      saw_fix |= buf_fix_r;
      saw_disc |= disconnect_r;
      if (retry_req_r === 1'b1)
        res = 2'd1;
      else if (done_r === 1'b1)
        res = 2'd2;
      else if (err_final_r === 1'b1)
        res = 2'd3;
      else
        @(negedge core_clk);
    end
  endtask
  task automatic seq(input dcr_err_t e, input int n, input logic [1:0] f);
    for (int k = 0; k < n; k++) begin
      attempt(e);
      chk(res === (k == n - 1 ? f : 2'd1), "retry outcome");
      if (res === 2'd1)
        chk(saw_disc === 1'b1, "stayed connected");
    end
  endtask
  task automatic pulse_log(input int d);
    @(negedge core_clk);
    log_rd = 1'b1;
    log_drive = d[DRV_W-1:0];
    @(negedge core_clk);
    log_rd = 1'b0;
    chk(log_valid_r === 1'b1, "log valid");
  endtask
  task automatic rotational_position_sensing(input int d, input logic s, input logic dn);
    @(negedge core_clk);
    rps_set = s;
    rps_done = dn;
    rps_drive = d[DRV_W-1:0];
    rps_done_drive = d[DRV_W-1:0];
    @(negedge core_clk);
    {rps_set, rps_done} = 2'b00;
  endtask
  task automatic t_corr();
    ecc_pattern = 24'h008100;
    ecc_disp = 16'h0123;
    start(0, 16'h0010);
    attempt(6'h20);
    chk(res === 2'd2 && sense_r === {1'b1, 40'h0081000123}, "sense");
    chk((24'h5ac30f ^ 24'h008100 ^ sense_r.pattern) === 24'h5ac30f,
      "host repair");
  endtask
  task automatic t_hak();
    start(0, 16'h0050);
    attempt(6'h10);
    chk(res === 2'd1 && saw_fix === 1'b1 && use_buf_r === 1'b1, "fix");
    attempt(6'h00);
    chk(res === 2'd2, "buffer retry done");
    start(0, 16'h0050);
    seq(6'h10, 2, 2'd3);
  endtask
  task automatic t_uncorr();
    int r0;
    r0 = n_reissue;
    start(1, 16'h0020);
    seq(6'h08, 2, 2'd1);
    attempt(6'h00);
    chk(res === 2'd2 && n_reissue - r0 === 2, "uncorr recovered");
    start(1, 16'h0020);
    seq(6'h08, 3, 2'd3);
  endtask
  task automatic t_seek();
    start(2, 16'h0030);
    repeat (3) begin
      @(negedge core_clk);
      seek_issued = 1'b1;
      @(negedge core_clk);
      seek_issued = 1'b0;
    end
    seq(6'h04, 10, 2'd1);
    attempt(6'h00);
    chk(res === 2'd2, "seek recovered");
    start(2, 16'h0030);
    seq(6'h04, 11, 2'd3);
  endtask
  task automatic t_log();
    pulse_log(1);
    chk(log_data_r === {32'h60, 16'h0, 24'h01}, "drive 1 log");
    pulse_log(2);
    chk(log_data_r === {32'h160, 16'h3, 24'h010000}, "drive 2");
    pulse_log(2);
    chk(log_data_r === '0, "log cleared");
  endtask
  task automatic t_thr();
    repeat (2) begin
      start(1, 16'h0020);
      seq(6'h08, 1, 2'd1);
      attempt(6'h00);
    end
    repeat (4) @(negedge core_clk);
    start(1, 16'h0020);
    chk(unit_check_r === 1'b1, "threshold check");
    start(1, 16'h0020);
    attempt(6'h00);
    chk(res === 2'd2, "runs after check");
    pack_removed_pin[6] = 1'b1;
    repeat (5) @(negedge core_clk);
    start(6, 16'h0020);
    chk(unit_check_r === 1'b1, "pack removed");
  endtask
  task automatic t_over_alt();
    start(3, 16'h0060);
    seq(6'h01, 1, 2'd1);
    attempt(6'h00);
    chk(res === 2'd2, "overrun recovered");
    start(3, 16'h0060);
    seq(6'h01, 2, 2'd3);
    alt_loc = 16'h0abc;
    start(5, 16'h0040);
    seq(6'h02, 1, 2'd1);
    chk(seek_trk_r === 16'h0abc, "alternate seek");
    attempt(6'h00);
    chk(res === 2'd2 && eff_trk_r === 16'h0abc, "alternate done");
  endtask
  task automatic t_spare_rps();
    @(negedge core_clk);
    spare_assign = 1'b1;
    spare_drive = 3'h4;
    spare_bad_trk = 16'h0100;
    spare_alt_trk = 16'h0f00;
    @(negedge core_clk);
    spare_assign = 1'b0;
    diag_plug_pin[7] = 1'b1;
    start(4, 16'h0100);
    attempt(6'h00);
    chk(res === 2'd2 && eff_trk_r === 16'h0f00, "spare redirect");
    start(7, 16'h0000);
    chk(cmd_reject_r === 1'b1 && offline_r === 8'h80, "offline");
    for (int d = 0; d < 8; d++) begin
      rotational_position_sensing(d, 1'b1, 1'b0);
      chk(rps_reject_r === (d == 7), "sensing slot");
    end
    rotational_position_sensing(2, 1'b1, 1'b0);
    chk(rps_reject_r === 1'b1 && rps_active_r === 8'h7f, "slot busy");
    rotational_position_sensing(2, 1'b0, 1'b1);
    chk(rps_active_r === 8'h7b, "slot freed");
  endtask
  initial begin
    {cmd_start, op_end, seek_issued, rps_set, rps_done, log_rd} = '0;
    {spare_assign, cmd_drive, rps_drive, rps_done_drive, spare_drive} = '0;
    {log_drive, cmd_track, alt_loc, spare_bad_trk, spare_alt_trk} = '0;
    {ecc_pattern, ecc_disp, pack_removed_pin, diag_plug_pin} = '0;
    op_err = '0;
    xfer_bytes = 16'h0010;
    lat = 4'h0;
    n_mismatch = 0;
    n_compared = 0;
    rstn = 1'b0;
    repeat (20) @(negedge core_clk);
    rstn = 1'b1;
    t_corr();
    t_hak();
    t_uncorr();
    lat = 4'h3;
    t_seek();
    t_log();
    t_thr();
    t_over_alt();
    lat = 4'h0;
    t_spare_rps();
    chk(chk_bytes_r === 4'h2, "check bytes");
    report_and_stop();
  end
endmodule
